// ---- rtl/gtfc_regs.sv ----
// Behaviour
// - Dual-mode trims A1, B0, B1: five bits.
// - B0 dual trim from own zero-reset register.
// - Separate four-register single-channel trim set.
// - Trims load fuse defaults after reset.
// - Share bit: channel B uses A coefficients.
// - Merge bit joins both filters into one.
// - Weight field scales all but center tap.
// - Mode two enables filter, zero disables.
//
// The AXI4-Lite slave port was chosen for this implementation.
module gtfc_regs
    import gtfc_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TRIM_SETS*2*TRIM_W-1:0] fuse_trim,
    input wire logic single_channel_mode,
    input wire logic serial_link_enable,
    output logic [TRIM_W-1:0] trim_a_bank0,
    output logic [TRIM_W-1:0] trim_a_bank1,
    output logic [TRIM_W-1:0] trim_b_bank0,
    output logic [TRIM_W-1:0] trim_b_bank1,
    output logic coefficient_share,
    output logic filter_merge,
    output logic [SCW_W-1:0] side_coefficient_weight,
    output logic [4:0] side_lsb_shift,
    output logic filter_enable,
    output logic fuse_loaded
);

    initial
    begin
        if (ADDR_W < 14 || ADDR_W > 32)
        begin
            $error("ADDR_W must lie between 14 and 32.");
        end
    end

    gtfc_reg_t reg_q [NUM_REGS];
    logic [NUM_REGS-1:0] wr_sel;
    logic fuse_pending_q;
    logic [TRIM_W-1:0] active_q [TRIM_SETS];

    logic aw_have_q;
    logic w_have_q;
    logic [11:0] aw_idx_q;
    logic [REG_W-1:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [11:0] ar_idx;

    // Tells whether a register index maps onto a storage slot.
    function automatic logic decode_hit(input logic [11:0] idx);
        decode_hit = (idx >= IDX_TRIM_A0_DUAL && idx <= IDX_TRIM_B1_SINGLE)
            || idx == IDX_FILTER_CFG;
    endfunction : decode_hit

    function automatic logic [3:0] decode_slot(input logic [11:0] idx);
        logic [11:0] off;
        off = idx - IDX_TRIM_A0_DUAL;
        if (idx == IDX_FILTER_CFG)
        begin
            decode_slot = 4'(SLOT_CFG);
        end
        else
        begin
            decode_slot = off[3:0];
        end
    endfunction : decode_slot

    // Write channel handshakes; address and data are taken in either order.
    assign s_axi_awready = ce && !aw_have_q && !bvalid_q;
    assign s_axi_wready = ce && !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wr_fire = ce && aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            aw_idx_q <= '0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[13:2];
            end
            else if (wr_fire)
            begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata[REG_W-1:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            else if (wr_fire)
            begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                if (decode_hit(aw_idx_q) || aw_idx_q == IDX_STATUS)
                begin
                    bresp_q <= RESP_OKAY;
                end
                else
                begin
                    bresp_q <= RESP_SLVERR;
                end
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb
    begin
        wr_sel = '0;
        if (wr_fire && wstrb0_q && decode_hit(aw_idx_q))
        begin
            wr_sel[decode_slot(aw_idx_q)] = 1'b1;
        end
    end

    // Fuse defaults are loaded once, in the first enabled cycle after reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fuse_pending_q <= 1'b1;
        end
        else if (ce)
        begin
            fuse_pending_q <= 1'b0;
        end
    end

    assign fuse_loaded = !fuse_pending_q;

    // Eight trim registers and the filter configuration register.
    generate
        for (genvar k = 0; k < NUM_REGS; k++)
        begin : g_reg
            if (k < SLOT_CFG)
            begin : g_trim
                gtfc_reg8 #(
                    .W(REG_W),
                    .RESET(REG_RESET)
                ) u_trim (
                    .aclk(aclk),
                    .aresetn(aresetn),
                    .ce(ce),
                    .wr_en(wr_sel[k]),
                    .wr_data(wdata_q),
                    .load_en(fuse_pending_q),
                    .load_data({3'h0, fuse_trim[k*TRIM_W +: TRIM_W]}),
                    .q(reg_q[k])
                );
            end
            else
            begin : g_cfg
                gtfc_reg8 #(
                    .W(REG_W),
                    .RESET(REG_RESET)
                ) u_cfg (
                    .aclk(aclk),
                    .aresetn(aresetn),
                    .ce(ce),
                    .wr_en(wr_sel[k]),
                    .wr_data(wdata_q),
                    .load_en(1'b0),
                    .load_data(REG_RESET),
                    .q(reg_q[k])
                );
            end
        end
    endgenerate

    // The channel mode picks the trim set that drives the cores.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < TRIM_SETS; i++)
            begin
                active_q[i] <= '0;
            end
        end
        else if (ce)
        begin
            for (int i = 0; i < TRIM_SETS; i++)
            begin
                if (single_channel_mode)
                begin
                    active_q[i] <= reg_q[SLOT_SINGLE + i][TRIM_W-1:0];
                end
                else
                begin
                    active_q[i] <= reg_q[i][TRIM_W-1:0];
                end
            end
        end
    end

    assign trim_a_bank0 = active_q[0];
    assign trim_a_bank1 = active_q[1];
    assign trim_b_bank0 = active_q[2];
    assign trim_b_bank1 = active_q[3];

    // Filter configuration fields steer the equalization filter.
    assign coefficient_share = reg_q[SLOT_CFG][SHARE_BIT];
    assign filter_merge = reg_q[SLOT_CFG][MERGE_BIT];
    assign side_coefficient_weight = reg_q[SLOT_CFG][SCW_LSB +: SCW_W];
    assign side_lsb_shift = SCW_BIAS - {2'h0, side_coefficient_weight};
    assign filter_enable = reg_q[SLOT_CFG][MODE_LSB +: MODE_W] == MODE_ENABLE;

    // Read channel: one read at a time, answered one cycle after it is taken.
    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign ar_idx = s_axi_araddr[13:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= '0;
                rresp_q <= RESP_OKAY;
                if (decode_hit(ar_idx))
                begin
                    rdata_q[REG_W-1:0] <= reg_q[decode_slot(ar_idx)];
                end
                else if (ar_idx == IDX_STATUS)
                begin
                    rdata_q[ST_SINGLE_BIT] <= single_channel_mode;
                    rdata_q[ST_LINK_BIT] <= serial_link_enable;
                    rdata_q[ST_FILTER_BIT] <= filter_enable;
                    rdata_q[ST_FUSE_BIT] <= fuse_loaded;
                end
                else
                begin
                    rresp_q <= RESP_SLVERR;
                end
            end
            else if (s_axi_rready)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    trim_a1_write_a: assert property (ce && wr_fire && wstrb0_q
        && aw_idx_q == IDX_TRIM_A1_DUAL |=> reg_q[1] == $past(wdata_q))
        else $error("A1 dual trim did not take the written value.");
    b0_dual_read_a: assert property (ce && s_axi_arvalid && s_axi_arready
        && ar_idx == IDX_TRIM_B0_DUAL |=> s_axi_rvalid
        && s_axi_rdata == {24'h0, $past(reg_q[2])})
        else $error("B0 dual trim read returned a wrong value.");
    single_set_a: assert property (ce && single_channel_mode
        |=> trim_b_bank1 == $past(reg_q[7][TRIM_W-1:0]))
        else $error("Single mode does not apply the single trim set.");
    fuse_default_a: assert property (ce && fuse_pending_q && !wr_fire
        |=> reg_q[5] == {3'h0, $past(fuse_trim[5*TRIM_W +: TRIM_W])} && fuse_loaded)
        else $error("Fuse default not loaded after reset.");
    coef_share_a: assert property (ce && wr_sel[SLOT_CFG]
        |=> coefficient_share == $past(wdata_q[SHARE_BIT]))
        else $error("Share output does not follow the written bit.");
    filter_merge_a: assert property (ce && wr_sel[SLOT_CFG]
        |=> filter_merge == $past(wdata_q[MERGE_BIT]))
        else $error("Merge output does not follow the written bit.");
    side_weight_a: assert property (side_lsb_shift
        == 5'(16 - int'(reg_q[SLOT_CFG][4:2])))
        else $error("Side weight shift does not match the field.");
    filter_mode_a: assert property (ce && wr_sel[SLOT_CFG]
        |=> filter_enable == ($past(wdata_q[1:0]) == 2'h2))
        else $error("Filter enable does not follow the mode field.");
    dual_set_a: assert property (ce && !single_channel_mode
        ##1 ce && !single_channel_mode |-> trim_a_bank0 == $past(reg_q[0][TRIM_W-1:0]))
        else $error("Dual mode does not apply the dual trim set.");
    write_resp_a: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready)
        else $error("Write response missing one cycle after the write.");
    cfg_write_c: cover property (wr_sel[SLOT_CFG] ##[1:20] s_axi_bvalid && s_axi_bready);
    single_switch_c: cover property (!single_channel_mode ##1 single_channel_mode);
    unmapped_read_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : gtfc_regs

// ---- rtl/gtfc_pkg.sv ----
package gtfc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [11:0] IDX_TRIM_A0_DUAL = 12'h350;
    localparam logic [11:0] IDX_TRIM_A1_DUAL = 12'h351;
    localparam logic [11:0] IDX_TRIM_B0_DUAL = 12'h352;
    localparam logic [11:0] IDX_TRIM_B1_DUAL = 12'h353;
    localparam logic [11:0] IDX_TRIM_A0_SINGLE = 12'h354;
    localparam logic [11:0] IDX_TRIM_A1_SINGLE = 12'h355;
    localparam logic [11:0] IDX_TRIM_B0_SINGLE = 12'h356;
    localparam logic [11:0] IDX_TRIM_B1_SINGLE = 12'h357;
    localparam logic [11:0] IDX_FILTER_CFG = 12'h400;
    localparam logic [11:0] IDX_STATUS = 12'h401;

    localparam int REG_W = 8;
    localparam int TRIM_W = 5;
    localparam int TRIM_SETS = 4;
    localparam int NUM_REGS = 9;
    localparam int SLOT_SINGLE = 4;
    localparam int SLOT_CFG = 8;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;

    // Filter configuration fields.
    localparam int SHARE_BIT = 6;
    localparam int MERGE_BIT = 5;
    localparam int SCW_LSB = 2;
    localparam int SCW_W = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_ENABLE = 2'h2;
    localparam logic [4:0] SCW_BIAS = 5'h10;

    // Status fields.
    localparam int ST_SINGLE_BIT = 0;
    localparam int ST_LINK_BIT = 1;
    localparam int ST_FILTER_BIT = 2;
    localparam int ST_FUSE_BIT = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [REG_W-1:0] gtfc_reg_t;

endpackage : gtfc_pkg

// ---- rtl/gtfc_reg8.sv ----
module gtfc_reg8
    import gtfc_pkg::*;
#(
    parameter int W = REG_W,
    parameter logic [W-1:0] RESET = '0
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    input wire logic load_en,
    input wire logic [W-1:0] load_data,
    output logic [W-1:0] q
);

    // A bus write in the load cycle wins over the fuse default.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= RESET;
        end
        else if (ce)
        begin
            if (wr_en)
            begin
                q <= wr_data;
            end
            else if (load_en)
            begin
                q <= load_data;
            end
        end
    end

endmodule : gtfc_reg8

// ---- testbench/gtfc_regs_tb_top.sv ----
module gtfc_regs_tb_top
    import gtfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, single_mode, link_en;
    logic share, merge, filt_en, fuse_done;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [TRIM_SETS*2*TRIM_W-1:0] fuse_trim;
    logic [4:0] ta0, ta1, tb0, tb1, lsb_shift;
    logic [2:0] scw;
    int fail_count, checks;

    gtfc_regs dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fuse_trim(fuse_trim),
        .single_channel_mode(single_mode), .serial_link_enable(link_en),
        .trim_a_bank0(ta0), .trim_a_bank1(ta1), .trim_b_bank0(tb0), .trim_b_bank1(tb1),
        .coefficient_share(share), .filter_merge(merge), .side_coefficient_weight(scw),
        .side_lsb_shift(lsb_shift), .filter_enable(filt_en), .fuse_loaded(fuse_done)
    );

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [4:0] fv(input int k);
        return 5'(3 * k + 1);
    endfunction : fv

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic timeout();
        fail_count++;
        $display("mismatch bus wait expected answer seen none");
        summarize();
    endtask : timeout

    // Both channels are offered together; each is dropped at the edge that takes it.
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        logic a, w, b;
        int n;
        n = 0;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b)
        begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            n++;
            if (n > 50) timeout();
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] resp);
        logic a, r;
        int n;
        n = 0;
        r = 1'b0;
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r)
        begin
            @(negedge aclk);
            a = arvalid && arready;
            r = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'b0;
            n++;
            if (n > 50) timeout();
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk("read data", {24'h0, exp}, d);
        chk("read resp", 32'(RESP_OKAY), 32'(r));
    endtask : rchk

    task automatic trims(input logic [4:0] a0, a1, b0, b1);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("trim_a_bank0", 32'(a0), 32'(ta0));
        chk("trim_a_bank1", 32'(a1), 32'(ta1));
        chk("trim_b_bank0", 32'(b0), 32'(tb0));
        chk("trim_b_bank1", 32'(b1), 32'(tb1));
    endtask : trims

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        single_mode <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask : do_reset

    task automatic t_fuse();
        for (int k = 0; k < 8; k++)
            rchk(IDX_TRIM_A0_DUAL + 12'(k), {3'h0, fv(k)});
        chk("fuse_loaded", 32'h1, 32'(fuse_done));
        trims(fv(0), fv(1), fv(2), fv(3));
        rchk(IDX_FILTER_CFG, 8'h00);
        chk("filter_enable", 32'h0, 32'(filt_en));
        $display("test fuse done");
    endtask : t_fuse

    task automatic t_rw();
        logic [1:0] r;
        for (int k = 0; k < 8; k++)
        begin
            wr(IDX_TRIM_A0_DUAL + 12'(k), 8'(8'he0 + 3 * k), 4'h1, r);
            chk("write resp", 32'(RESP_OKAY), 32'(r));
        end
        for (int k = 0; k < 8; k++)
            rchk(IDX_TRIM_A0_DUAL + 12'(k), 8'(8'he0 + 3 * k));
        $display("test rw done");
    endtask : t_rw

    task automatic t_mode();
        logic [1:0] r;
        for (int k = 0; k < 8; k++)
            wr(IDX_TRIM_A0_DUAL + 12'(k), 8'(3 * k + 8), 4'h1, r);
        trims(5'h08, 5'h0b, 5'h0e, 5'h11);
        wr(IDX_FILTER_CFG, 8'h20, 4'h1, r);
        chk("merge write resp", 32'(RESP_OKAY), 32'(r));
        @(posedge aclk);
        single_mode <= 1'b1;
        trims(5'h14, 5'h17, 5'h1a, 5'h1d);
        wr(IDX_TRIM_A0_SINGLE, 8'h1f, 4'h0, r);
        chk("masked write resp", 32'(RESP_OKAY), 32'(r));
        trims(5'h14, 5'h17, 5'h1a, 5'h1d);
        $display("test mode done");
    endtask : t_mode

    task automatic t_cfg();
        logic [1:0] r;
        logic [7:0] v;
        // Single-channel mode is turned off before the filter setup is changed.
        @(posedge aclk);
        single_mode <= 1'b0;
        for (int m = 0; m < 4; m++)
            for (int w = 0; w < 7; w++)
            begin
                v = {1'b0, 1'(w), 1'(w >> 1), 3'(w), 2'(m)};
                wr(IDX_FILTER_CFG, v, 4'h1, r);
                @(negedge aclk);
                chk("coefficient_share", 32'(v[6]), 32'(share));
                chk("filter_merge", 32'(v[5]), 32'(merge));
                chk("side_weight", 32'(w), 32'(scw));
                chk("side_lsb_shift", 32'(16 - w), 32'(lsb_shift));
                chk("filter_enable", 32'(m == 2), 32'(filt_en));
            end
        wr(IDX_FILTER_CFG, 8'h7a, 4'h1, r);
        rchk(IDX_FILTER_CFG, 8'h7a);
        $display("test cfg done");
    endtask : t_cfg

    task automatic t_err();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h358, 8'h55, 4'h1, r);
        chk("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
        rd(12'h358, d, r);
        chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
        rchk(IDX_TRIM_B1_SINGLE, 8'h1d);
        wr(IDX_STATUS, 8'hff, 4'h1, r);
        chk("status write resp", 32'(RESP_OKAY), 32'(r));
        @(posedge aclk);
        link_en <= 1'b1;
        rchk(IDX_STATUS, 8'((1 << ST_FUSE_BIT) | (1 << ST_FILTER_BIT) | (1 << ST_LINK_BIT)));
        @(posedge aclk);
        ce <= 1'b0;
        link_en <= 1'b0;
        @(negedge aclk);
        chk("frozen ready", 32'h0, 32'({awready, wready, arready}));
        @(posedge aclk);
        ce <= 1'b1;
        $display("test err done");
    endtask : t_err

    initial
    begin
        aresetn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 16'h0000;
        araddr = 16'h0000;
        wdata = 32'h0;
        wstrb = 4'h0;
        single_mode = 1'b0;
        link_en = 1'b0;
        fail_count = 0;
        checks = 0;
        for (int k = 0; k < 8; k++)
            fuse_trim[5 * k +: 5] = fv(k);
        do_reset();
        t_fuse();
        t_rw();
        t_mode();
        t_cfg();
        t_err();
        do_reset();
        t_fuse();
        summarize();
    end

endmodule : gtfc_regs_tb_top
